/* logic/etp_consts.svh */
// constants for the eight-bit timer with compare output
`ifndef ETP_CONSTS_SVH
`define ETP_CONSTS_SVH

// ----------------------------------------------------------------
// counter limits and reset values
// ----------------------------------------------------------------
`define ETP_MAX          8'hff
`define ETP_BOTTOM       8'h00
`define ETP_COUNT_RST    8'h00
`define ETP_COMPARE_RST  8'h00
`define ETP_FLAGS_RST    2'h0

// ----------------------------------------------------------------
// flag and mask bit positions
// ----------------------------------------------------------------
`define ETP_FLAG_OVF     0
`define ETP_FLAG_CMP     1

// ----------------------------------------------------------------
// prescaler width and tap masks (tick when masked bits all ones)
// ----------------------------------------------------------------
`define ETP_PRESCALE_BITS 10
`define ETP_DIV8_MASK     10'h0007
`define ETP_DIV64_MASK    10'h003f
`define ETP_DIV256_MASK   10'h00ff
`define ETP_DIV1024_MASK  10'h03ff

`endif

/* logic/etp_pkg.sv */
// types shared by the eight-bit timer and its users
package etp_pkg;

	// ----------------------------------------------------------------
	// waveform generation modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		mode_normal = 2'b00,
		mode_phase  = 2'b01,
		mode_ctc    = 2'b10,
		mode_fast   = 2'b11
	} etp_mode_t;

	// ----------------------------------------------------------------
	// counter clock sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		cs_stop     = 3'b000,
		cs_div1     = 3'b001,
		cs_div8     = 3'b010,
		cs_div64    = 3'b011,
		cs_div256   = 3'b100,
		cs_div1024  = 3'b101,
		cs_ext_fall = 3'b110,
		cs_ext_rise = 3'b111
	} etp_clksel_t;

endpackage

/* logic/etp_timer.sv */
// eight-bit timer/counter with one compare channel and pwm output
//
// What this block does
// - counter and compare value are eight bits
// - flags visible, each gated by mask bit
// - overflow and compare match raise requests
// - count from prescaler or external pin
// - clock select picks source and edge
// - normal mode tops at max, immediate update
// - phase pwm: update at top, overflow bottom
// - fast pwm: buffer loads at bottom
// - nonzero output mode overrides port value
// - driver enabled only by direction bit
// - non-pwm: off, toggle, clear, set on match
// - fast pwm: clear/set on match, bottom opposite
// - fast pwm top match ignored, bottom acts
// - phase pwm: action flips with count direction
// - phase pwm top match ignored, top acts
`timescale 1ns/1ps
`include "etp_consts.svh"

module etp_timer
#(
	parameter int PRESCALE_BITS = `ETP_PRESCALE_BITS
)
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                clk_en,
	input  wire etp_pkg::etp_mode_t  waveform_mode_bits,
	input  wire logic [1:0]          compare_output_bits,
	input  wire etp_pkg::etp_clksel_t clock_select,
	input  wire logic                compare_value_wr,
	input  wire logic [7:0]          compare_value_in,
	input  wire logic                timer_count_wr,
	input  wire logic [7:0]          timer_count_in,
	input  wire logic                force_compare,
	input  wire logic [1:0]          timer_mask_reg,
	input  wire logic [1:0]          flag_clear_wr,
	input  wire logic                vector_ack_ovf,
	input  wire logic                vector_ack_cmp,
	input  wire logic                ext_count_pin,
	input  wire logic                pin_direction,
	input  wire logic                port_value,
	output logic [7:0]               timer_count,
	output logic [7:0]               compare_value,
	output logic [1:0]               timer_flag_reg,
	output logic                     irq_overflow,
	output logic                     irq_compare,
	output logic                     compare_output_pin_o,
	output logic                     compare_output_pin_oe
);
	import etp_pkg::*;

	// the tap masks assume at least a ten-bit prescaler
	if (PRESCALE_BITS < `ETP_PRESCALE_BITS)
	begin : g_check
		$error("etp_timer: PRESCALE_BITS must be at least 10");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// apply an output action: 00 hold, 01 toggle, 10 clear, 11 set
	function automatic logic oc_apply(input logic cur, input logic [1:0] act);
		unique case (act)
			2'b00: oc_apply = cur;
			2'b01: oc_apply = ~cur;
			2'b10: oc_apply = 1'b0;
			2'b11: oc_apply = 1'b1;
		endcase
	endfunction

	// prescaler tap: all masked bits ones marks the last clock of a period
	function automatic logic tap_hit(input logic [PRESCALE_BITS-1:0] cnt,
		input logic [`ETP_PRESCALE_BITS-1:0] mask);
		tap_hit = ((cnt[`ETP_PRESCALE_BITS-1:0] & mask) == mask);
	endfunction

	logic [PRESCALE_BITS-1:0] presc_reg;
	logic [2:0]               ext_sync_reg;
	logic                     ext_level_reg;
	logic                     ext_prev_reg;
	logic                     tick;
	logic [7:0]               timer_count_reg;
	logic [7:0]               count_next;
	logic                     count_up_reg;
	logic                     up_next;
	logic [7:0]               compare_value_reg;
	logic [7:0]               compare_buf_reg;
	logic [7:0]               buf_next;
	logic                     block_reg;
	logic [1:0]               flags_reg;
	logic                     oc_reg;
	logic [1:0]               oc_act;
	logic [7:0]               top;
	logic                     at_max;
	logic                     match;
	logic                     top_ignored;
	logic                     ovf_event;
	logic                     load_buf;

	// ----------------------------------------------------------------
	// clock source selection
	// ----------------------------------------------------------------
	// free-running prescaler; shared taps so the divide ratio can change on the fly
	always_ff @(posedge clk)
	begin
		if (reset)
			presc_reg <= '0;
		else if (clk_en)
			presc_reg <= presc_reg + 1'b1;
	end

	// external pin: three flops, a level counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ext_sync_reg  <= 3'h0;
			ext_level_reg <= 1'b0;
			ext_prev_reg  <= 1'b0;
		end
		else if (clk_en)
		begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_count_pin};
			if (ext_sync_reg[1] == ext_sync_reg[2])
				ext_level_reg <= ext_sync_reg[2];
			ext_prev_reg <= ext_level_reg;
		end
	end

	// one-cycle count enable from the chosen source and edge
	always_comb
	begin
		unique case (clock_select)
			cs_stop:     tick = 1'b0;
			cs_div1:     tick = 1'b1;
			cs_div8:     tick = tap_hit(presc_reg, `ETP_DIV8_MASK);
			cs_div64:    tick = tap_hit(presc_reg, `ETP_DIV64_MASK);
			cs_div256:   tick = tap_hit(presc_reg, `ETP_DIV256_MASK);
			cs_div1024:  tick = tap_hit(presc_reg, `ETP_DIV1024_MASK);
			cs_ext_fall: tick = ext_prev_reg & ~ext_level_reg;
			cs_ext_rise: tick = ~ext_prev_reg & ext_level_reg;
		endcase
	end

	// ----------------------------------------------------------------
	// counter sequencing
	// ----------------------------------------------------------------
	// top is the compare value only in ctc; every other mode tops at max
	assign top    = (waveform_mode_bits == mode_ctc) ? compare_value_reg : `ETP_MAX;
	assign at_max = (timer_count_reg == `ETP_MAX);

	// phase pwm turns at max going up and at bottom going down; the rest wrap at top
	always_comb
	begin
		up_next = count_up_reg;
		if (waveform_mode_bits == mode_phase)
		begin
			up_next    = count_up_reg ? ~at_max : (timer_count_reg == `ETP_BOTTOM);
			count_next = up_next ? timer_count_reg + 8'h01 : timer_count_reg - 8'h01;
		end
		else
			count_next = (timer_count_reg == top) ? `ETP_BOTTOM : timer_count_reg + 8'h01;
	end

	// overflow: phase pwm at the bottom turn, the rest when leaving max
	assign ovf_event = tick & ((waveform_mode_bits == mode_phase) ?
		(~count_up_reg & (timer_count_reg == `ETP_BOTTOM)) : at_max);

	// a software count write wins over a tick and blocks the next match
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			timer_count_reg <= `ETP_COUNT_RST;
			count_up_reg    <= 1'b1;
			block_reg       <= 1'b0;
		end
		else if (clk_en)
		begin
			if (timer_count_wr)
			begin
				timer_count_reg <= timer_count_in;
				block_reg       <= 1'b1;
			end
			else if (tick)
			begin
				timer_count_reg <= count_next;
				count_up_reg    <= up_next;
				block_reg       <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// compare value and its double buffer
	// ----------------------------------------------------------------
	assign buf_next = compare_value_wr ? compare_value_in : compare_buf_reg;
	// pwm modes load only at the update point so a period is never cut short
	assign load_buf = tick & at_max &
		((waveform_mode_bits == mode_fast) | ((waveform_mode_bits == mode_phase) & count_up_reg));

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			compare_buf_reg   <= `ETP_COMPARE_RST;
			compare_value_reg <= `ETP_COMPARE_RST;
		end
		else if (clk_en)
		begin
			compare_buf_reg <= buf_next;
			if (compare_value_wr && (waveform_mode_bits == mode_normal || waveform_mode_bits == mode_ctc))
				compare_value_reg <= compare_value_in;
			else if (load_buf)
				compare_value_reg <= buf_next;
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags
	// ----------------------------------------------------------------
	assign match = tick & ~block_reg & (timer_count_reg == compare_value_reg);

	// set beats clear so an event landing on a clear is never lost
	always_ff @(posedge clk)
	begin
		if (reset)
			flags_reg <= `ETP_FLAGS_RST;
		else if (clk_en)
		begin
			if (ovf_event)
				flags_reg[`ETP_FLAG_OVF] <= 1'b1;
			else if (flag_clear_wr[`ETP_FLAG_OVF] || vector_ack_ovf)
				flags_reg[`ETP_FLAG_OVF] <= 1'b0;
			if (match)
				flags_reg[`ETP_FLAG_CMP] <= 1'b1;
			else if (flag_clear_wr[`ETP_FLAG_CMP] || vector_ack_cmp)
				flags_reg[`ETP_FLAG_CMP] <= 1'b0;
		end
	end

	assign irq_overflow = flags_reg[`ETP_FLAG_OVF] & timer_mask_reg[`ETP_FLAG_OVF];
	assign irq_compare  = flags_reg[`ETP_FLAG_CMP] & timer_mask_reg[`ETP_FLAG_CMP];

	// ----------------------------------------------------------------
	// compare output waveform
	// ----------------------------------------------------------------
	assign top_ignored = compare_output_bits[1] & (compare_value_reg == `ETP_MAX);

	always_comb
	begin
		oc_act = 2'b00;
		unique case (waveform_mode_bits)
			mode_normal, mode_ctc:
				if (match || force_compare)
					oc_act = compare_output_bits;
			mode_fast:
				if (compare_output_bits[1])
				begin
					if (match && !top_ignored)
						oc_act = {1'b1, compare_output_bits[0]};
					else if (tick && at_max)
						oc_act = {1'b1, ~compare_output_bits[0]};
				end
			mode_phase:
				if (compare_output_bits[1])
				begin
					if (match && !top_ignored)
						oc_act = {1'b1, compare_output_bits[0] ^ ~count_up_reg};
					else if (top_ignored && tick && at_max && count_up_reg)
						oc_act = {1'b1, ~compare_output_bits[0]};
				end
		endcase
	end

	// pwm forcing is not allowed; the force strobe only acts in non-pwm modes
	always_ff @(posedge clk)
	begin
		if (reset)
			oc_reg <= 1'b0;
		else if (clk_en)
			oc_reg <= oc_apply(oc_reg, oc_act);
	end

	// ----------------------------------------------------------------
	// pin and visible state
	// ----------------------------------------------------------------
	assign compare_output_pin_o  = (compare_output_bits != 2'b00) ? oc_reg : port_value;
	assign compare_output_pin_oe = pin_direction;
	assign timer_count           = timer_count_reg;
	assign compare_value         = compare_value_reg;
	assign timer_flag_reg        = flags_reg;

endmodule

/* sim/etp_timer_monitor.sv */
// concurrent checks on the eight-bit timer ports
`timescale 1ns/1ps

module etp_timer_monitor
#(
	parameter int PRESCALE_BITS = 10
)
(
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic                 clk_en,
	input wire etp_pkg::etp_mode_t   waveform_mode_bits,
	input wire logic [1:0]           compare_output_bits,
	input wire etp_pkg::etp_clksel_t clock_select,
	input wire logic                 compare_value_wr,
	input wire logic [7:0]           compare_value_in,
	input wire logic                 timer_count_wr,
	input wire logic [7:0]           timer_count_in,
	input wire logic                 force_compare,
	input wire logic [1:0]           timer_mask_reg,
	input wire logic [1:0]           flag_clear_wr,
	input wire logic                 vector_ack_ovf,
	input wire logic                 vector_ack_cmp,
	input wire logic                 ext_count_pin,
	input wire logic                 pin_direction,
	input wire logic                 port_value,
	input wire logic [7:0]           timer_count,
	input wire logic [7:0]           compare_value,
	input wire logic [1:0]           timer_flag_reg,
	input wire logic                 irq_overflow,
	input wire logic                 irq_compare,
	input wire logic                 compare_output_pin_o,
	input wire logic                 compare_output_pin_oe
);
	import etp_pkg::*;
	// -------------------------------------------------------
	// a tick on every clock, not masked by a counter load
	// -------------------------------------------------------
	wire run1 = clk_en && clock_select == cs_div1 && !timer_count_wr;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_OE_DIR: assert property (compare_output_pin_oe == pin_direction)
		else $error("driver enable differs from direction bit");
	AST_PORT_MUX: assert property (compare_output_bits == 2'h0 |-> compare_output_pin_o == port_value)
		else $error("disconnected pin does not show port value");
	AST_IRQ: assert property (irq_overflow == (timer_flag_reg[0] & timer_mask_reg[0])
		&& irq_compare == (timer_flag_reg[1] & timer_mask_reg[1])) else $error("request differs from flag and mask");
	AST_CMP_FLAG: assert property (run1 && waveform_mode_bits == mode_normal
		&& timer_count == compare_value && !$past(timer_count_wr) |=> timer_flag_reg[1]) else $error("no match flag");
	AST_OVF_NORMAL: assert property (run1 && waveform_mode_bits == mode_normal && timer_count == 8'hff
		|=> timer_flag_reg[0] && timer_count == 8'h00) else $error("no overflow at max");
	AST_CTC_WRAP: assert property (run1 && waveform_mode_bits == mode_ctc && timer_count == compare_value
		&& !$past(timer_count_wr) |=> timer_count == 8'h00) else $error("count not cleared on match");
	AST_FAST_BOTTOM: assert property (run1 && waveform_mode_bits == mode_fast && compare_output_bits[1]
		&& timer_count == 8'hff && compare_value != 8'hff |=> compare_output_bits == 2'h0
		|| compare_output_pin_o == !$past(compare_output_bits[0])) else $error("wrong pin level at bottom");
	AST_FLAG_CLR: assert property (clk_en && clock_select == cs_stop && flag_clear_wr[0]
		|=> !timer_flag_reg[0]) else $error("overflow flag not cleared");
	COV_CTC: cover property (waveform_mode_bits == mode_ctc && timer_count == compare_value);
	COV_FAST: cover property (waveform_mode_bits == mode_fast && $rose(compare_output_pin_o));
	COV_OVF: cover property ($rose(timer_flag_reg[0]));
endmodule

bind etp_timer etp_timer_monitor #(.PRESCALE_BITS(PRESCALE_BITS)) etp_timer_monitor_inst
(
	.clk, .reset, .clk_en, .waveform_mode_bits, .compare_output_bits, .clock_select, .compare_value_wr,
	.compare_value_in, .timer_count_wr, .timer_count_in, .force_compare, .timer_mask_reg, .flag_clear_wr,
	.vector_ack_ovf, .vector_ack_cmp, .ext_count_pin, .pin_direction, .port_value, .timer_count,
	.compare_value, .timer_flag_reg, .irq_overflow, .irq_compare, .compare_output_pin_o, .compare_output_pin_oe
);

/* sim/tb.sv */
// self-checking bench for the eight-bit timer
`timescale 1ns/1ps

module tb;
	import etp_pkg::*;
	// -------------------------------------------------------
	// stimulus and observed signals
	// -------------------------------------------------------
	logic        clk = '0, reset = '1, clk_en = '1, compare_value_wr = '0, timer_count_wr = '0;
	logic        force_compare = '0, vector_ack_ovf = '0, vector_ack_cmp = '0, ext_count_pin = '0;
	logic        pin_direction = '1, port_value = '0, irq_overflow, irq_compare;
	logic        compare_output_pin_o, compare_output_pin_oe;
	logic [7:0]  compare_value_in = '0, timer_count_in = '0, timer_count, compare_value;
	logic [1:0]  compare_output_bits = '0, timer_mask_reg = '0, flag_clear_wr = '0, timer_flag_reg;
	etp_mode_t   waveform_mode_bits = mode_normal;
	etp_clksel_t clock_select = cs_stop;
	int          errors = 0, num_checks = 0;

	etp_timer etp_timer_inst
	(
		.clk, .reset, .clk_en, .waveform_mode_bits, .compare_output_bits, .clock_select, .compare_value_wr,
		.compare_value_in, .timer_count_wr, .timer_count_in, .force_compare, .timer_mask_reg, .flag_clear_wr,
		.vector_ack_ovf, .vector_ack_cmp, .ext_count_pin, .pin_direction, .port_value, .timer_count,
		.compare_value, .timer_flag_reg, .irq_overflow, .irq_compare, .compare_output_pin_o,
		.compare_output_pin_oe
	);

	// free-running clock
	always #5 clk = ~clk;

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// strobes are one cycle wide, launched on a falling edge
	task automatic wr_cv(input logic [7:0] v);
		@(negedge clk) compare_value_wr = 1'b1;
		compare_value_in = v;
		@(negedge clk) compare_value_wr = 1'b0;
	endtask

	task automatic wr_cnt(input logic [7:0] v);
		@(negedge clk) timer_count_wr = 1'b1;
		timer_count_in = v;
		@(negedge clk) timer_count_wr = 1'b0;
	endtask

	// sel 0 waits for a count value, 1 and 2 for a flag bit
	task automatic wait_for(input int sel, input logic [7:0] v);
		int i;
		for (i = 0; i < 600; i++)
		begin
			if (sel == 0 ? timer_count === v : timer_flag_reg[sel - 1] === 1'b1)
				break;
			@(negedge clk);
		end
		if (i == 600)
		begin
			errors++;
			$display("unexpected timeout: expected %h seen %h", v, timer_count);
			finish_test();
		end
	endtask

	task automatic run_match();
		compare_output_bits = 2'h1;
		timer_mask_reg = 2'h2;
		wr_cv(8'h05);
		wr_cnt(8'h03);
		clock_select = cs_div1;
		wait_for(2, 8'h00);
		chk("count with match flag", 8'h06, timer_count);
		chk("toggled pin", 8'h01, compare_output_pin_o);
		chk("compare request", 8'h01, irq_compare);
		vector_ack_cmp = 1'b1;
		@(negedge clk) vector_ack_cmp = 1'b0;
		chk("compare flag after ack", 8'h00, timer_flag_reg[1]);
		timer_mask_reg = 2'h3;
		wait_for(1, 8'h00);
		chk("count after overflow", 8'h00, timer_count);
		chk("overflow request", 8'h01, irq_overflow);
		vector_ack_ovf = 1'b1;
		@(negedge clk) vector_ack_ovf = 1'b0;
		clock_select = cs_stop;
		chk("overflow flag after ack", 8'h00, timer_flag_reg[0]);
	endtask

	// forced matches walk the non-pwm output modes; the flag must stay low
	// order toggle, set, clear so every action moves the pin; strobe held high throughout
	task automatic run_force();
		logic m;
		m = 1'b1;
		force_compare = 1'b1;
		for (int c = 1; c < 4; c++)
		begin
			compare_output_bits = (c == 1) ? 2'h1 : {1'b1, c == 2};
			@(negedge clk);
			m = (c == 1) ? ~m : (c == 2);
			chk("forced pin", {7'h00, m}, compare_output_pin_o);
			chk("flag after force", 8'h00, timer_flag_reg[1]);
		end
		force_compare = 1'b0;
		compare_output_bits = 2'h0;
		pin_direction = 1'b0;
		port_value = 1'b1;
		@(negedge clk);
		chk("port value on pin", 8'h01, compare_output_pin_o);
		chk("driver off", 8'h00, compare_output_pin_oe);
		pin_direction = 1'b1;
		port_value = 1'b0;
	endtask

	task automatic run_ctc();
		logic [7:0] top;
		top = 8'h00;
		waveform_mode_bits = mode_ctc;
		wr_cv(8'h03);
		chk("immediate compare value", 8'h03, compare_value);
		clock_select = cs_div1;
		repeat (12)
		begin
			@(negedge clk);
			if (timer_count > top)
				top = timer_count;
		end
		chk("highest count", 8'h03, top);
		chk("overflow flag", 8'h00, timer_flag_reg[0]);
		clock_select = cs_stop;
	endtask

	task automatic run_pwm();
		waveform_mode_bits = mode_fast;
		compare_output_bits = 2'h3;
		wr_cv(8'h80);
		chk("buffered compare value", 8'h03, compare_value);
		wr_cnt(8'hfd);
		clock_select = cs_div1;
		wait_for(0, 8'h00);
		chk("value loaded at bottom", 8'h80, compare_value);
		chk("pin cleared at bottom", 8'h00, compare_output_pin_o);
		chk("overflow at max", 8'h01, timer_flag_reg[0]);
		wait_for(0, 8'h81);
		chk("pin set at match", 8'h01, compare_output_pin_o);
		clock_select = cs_stop;
		waveform_mode_bits = mode_phase;
		compare_output_bits = 2'h2;
		flag_clear_wr = 2'h3;
		@(negedge clk) flag_clear_wr = 2'h0;
		wr_cv(8'hfe);
		wr_cnt(8'h7e);
		clock_select = cs_div1;
		wait_for(0, 8'h82);
		chk("pin cleared counting up", 8'h00, compare_output_pin_o);
		wait_for(0, 8'hff);
		wait_for(0, 8'hfd);
		chk("value loaded at top", 8'hfe, compare_value);
		chk("pin set counting down", 8'h01, compare_output_pin_o);
		wait_for(1, 8'h00);
		chk("count after bottom", 8'h01, timer_count);
	endtask

	// external edges: two with rising selected, two with falling selected
	task automatic run_ext();
		clock_select = cs_ext_rise;
		waveform_mode_bits = mode_normal;
		compare_output_bits = 2'h0;
		wr_cnt(8'h00);
		for (int k = 0; k < 4; k++)
		begin
			if (k == 2)
				clock_select = cs_ext_fall;
			ext_count_pin = ~ext_count_pin;
			repeat (10) @(negedge clk);
			chk("external count", (k == 3) ? 8'h02 : 8'h01, timer_count);
		end
		clk_en = 1'b0;
		clock_select = cs_div1;
		repeat (5) @(negedge clk);
		chk("frozen count", 8'h02, timer_count);
		clk_en = 1'b1;
	endtask

	// any 1024 clocks hold exactly 1024/ratio prescaler ticks, whatever its phase
	task automatic run_presc();
		logic [7:0] s0;
		@(negedge clk);
		for (int k = 0; k < 4; k++)
		begin
			s0 = timer_count;
			clock_select = etp_clksel_t'(k + 2);
			repeat (1024) @(negedge clk);
			chk("prescaled ticks", 8'(1024 >> ((k < 2) ? 3 * k + 3 : 2 * k + 4)), timer_count - s0);
		end
		clock_select = cs_stop;
	endtask

	// compare value at top: the match is dropped and only the bottom or top action moves the pin
	task automatic run_top();
		logic seen_low;
		seen_low = 1'b0;
		waveform_mode_bits = mode_fast;
		compare_output_bits = 2'h2;
		wr_cv(8'hff);
		wr_cnt(8'hfc);
		clock_select = cs_div1;
		wait_for(0, 8'hff);
		chk("pin cleared at match", 8'h00, compare_output_pin_o);
		wait_for(0, 8'h00);
		chk("pin set at bottom", 8'h01, compare_output_pin_o);
		chk("value loaded at bottom", 8'hff, compare_value);
		repeat (256)
		begin
			@(negedge clk);
			if (compare_output_pin_o !== 1'b1)
				seen_low = 1'b1;
		end
		chk("pin low with top match", 8'h00, {7'h00, seen_low});
		waveform_mode_bits = mode_phase;
		compare_output_bits = 2'h3;
		wait_for(0, 8'hff);
		wait_for(0, 8'hfe);
		chk("pin cleared at top", 8'h00, compare_output_pin_o);
		clock_select = cs_stop;
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		chk("count after reset", 8'h00, timer_count);
		chk("flags after reset", 8'h00, timer_flag_reg);
		run_match();
		run_force();
		run_ctc();
		run_pwm();
		run_ext();
		run_presc();
		run_top();
		finish_test();
	end
endmodule
